// ===== ccd_pkg.sv
// constants, encodings and carrier types of the clear/decrement/call core
// assumes a 14-bit instruction word and an 8-bit data path
`default_nettype none

package ccd_pkg;

	// ***********************************************************
	// widths and depths
	// ***********************************************************
	localparam int INSTR_W     = 14;
	localparam int PC_W        = 13;
	localparam int DATA_W      = 8;
	localparam int FILE_AW     = 7;
	localparam int TARGET_W    = 11;
	localparam int STACK_DEPTH = 8;

	// ***********************************************************
	// instruction encodings (opcode field values)
	// ***********************************************************
	localparam logic [13:0] OPC_DOG_KICK  = 14'h0064;
	localparam logic [2:0]  OPC_CALL_HI   = 3'h4;
	localparam logic [5:0]  OPC_INVERT_HI = 6'h09;
	localparam logic [5:0]  OPC_DOWN_HI   = 6'h03;
	localparam logic [5:0]  OPC_SKIP_HI   = 6'h0b;
	localparam logic [5:0]  OPC_CLEAR_HI  = 6'h01;

	// ***********************************************************
	// register byte offsets, field positions, reset values
	// ***********************************************************
	localparam logic [11:0] REG_ACCUM     = 12'h000;
	localparam logic [11:0] REG_STATUS    = 12'h004;
	localparam logic [11:0] REG_PC        = 12'h008;
	localparam logic [11:0] REG_PC_LATCH  = 12'h00c;
	localparam logic [11:0] REG_STACK_TOP = 12'h010;
	localparam logic [11:0] REG_FILE_ADDR = 12'h014;
	localparam logic [11:0] REG_FILE_DATA = 12'h018;
	localparam int STAT_ZERO_BIT   = 2;
	localparam int STAT_SLEEP_BIT  = 3;
	localparam int STAT_EXPIRE_BIT = 4;
	localparam int LATCH_UP_HI     = 4;
	localparam int LATCH_UP_LO     = 3;
	localparam logic [7:0]  ACCUM_RST  = 8'h00;
	localparam logic [12:0] PC_RST     = 13'h0000;
	localparam logic [7:0]  LATCH_RST  = 8'h00;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	// ***********************************************************
	// carrier types
	// ***********************************************************
	typedef enum logic [2:0] {
		OP_NOP, OP_DOG_KICK, OP_CALL, OP_INVERT,
		OP_CLEAR_F, OP_CLEAR_W, OP_DOWN, OP_DOWN_SKIP
	} ccd_op_type;

	typedef struct packed {
		ccd_op_type            op;
		logic                  to_file;
		logic [FILE_AW-1:0]    faddr;
		logic [TARGET_W-1:0]   target;
	} ccd_dec_type;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [11:0] addr;
	} ccd_bus_req_type;

	// split a fetched word into operation and operands
	function automatic ccd_dec_type ccd_decode(input logic [13:0] w);
		ccd_dec_type d;
		d.op      = OP_NOP;
		d.to_file = w[7];
		d.faddr   = w[6:0];
		d.target  = w[10:0];
		if (w == OPC_DOG_KICK) begin
			d.op = OP_DOG_KICK;
		end else if (w[13:11] == OPC_CALL_HI) begin
			d.op = OP_CALL;
		end else if (w[13:8] == OPC_INVERT_HI) begin
			d.op = OP_INVERT;
		end else if (w[13:8] == OPC_DOWN_HI) begin
			d.op = OP_DOWN;
		end else if (w[13:8] == OPC_SKIP_HI) begin
			d.op = OP_DOWN_SKIP;
		end else if (w[13:8] == OPC_CLEAR_HI) begin
			d.op = w[7] ? OP_CLEAR_F : OP_CLEAR_W;
		end
		return d;
	endfunction : ccd_decode

endpackage : ccd_pkg

`default_nettype wire

// ===== ccd_file_alu.sv
// result and zero test for the file-register operations
// assumes the operand is the addressed file register, read combinationally
`default_nettype none

module ccd_file_alu (
	input  wire ccd_pkg::ccd_op_type op,
	input  wire logic [7:0]          operand,
	output logic [7:0]               result,
	output logic                     is_zero
);
	import ccd_pkg::*;

	// ***********************************************************
	// operation select
	// ***********************************************************
	// decrement wraps naturally in 8 bits
	always_comb begin
		case (op)
			OP_INVERT:    result = ~operand;
			OP_DOWN:      result = operand - 8'h01;
			OP_DOWN_SKIP: result = operand - 8'h01;
			default:      result = 8'h00;
		endcase
	end

	// zero test of the 8-bit result
	assign is_zero = (result == 8'h00);

endmodule : ccd_file_alu

`default_nettype wire

// ===== ccd_ret_stack.sv
// circular hardware return stack, push only
// assumes pops are handled by a neighbouring return path
`default_nettype none

module ccd_ret_stack #(
	parameter int DEPTH = ccd_pkg::STACK_DEPTH,
	parameter int WIDTH = ccd_pkg::PC_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] push_data,
	output logic      [WIDTH-1:0] top
);
	import ccd_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// a non power of two depth would break the wrap of the pointer
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("stack depth must be a power of two");
	end

	logic [WIDTH-1:0] level_mem [DEPTH];
	logic [PW-1:0]    ptr_ff;
	logic [WIDTH-1:0] top_ff;

	// ***********************************************************
	// storage
	// ***********************************************************
	// overflow silently overwrites the oldest entry
	always_ff @(posedge clk) begin
		if (push)
			level_mem[ptr_ff] <= push_data;
	end

	// pointer and registered copy of the top entry
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_ff <= '0;
			top_ff <= '0;
		end else if (push) begin
			ptr_ff <= PW'(ptr_ff + 1'b1);
			top_ff <= push_data;
		end
	end

	assign top = top_ff;

endmodule : ccd_ret_stack

`default_nettype wire

// ===== ccd_core_exec.sv
// execute stage for watchdog kick, call, invert, clear and decrement ops
// assumes fetch hands words on a valid/ready pair and one master on ahb
// Behaviour
// - dog kick clears the watchdog count to zero
// - dog kick also clears the watchdog prescaler
// - dog kick sets both expired and sleep flags, nothing else
// - call pushes pc plus one onto the return stack
// - call loads its 11-bit target into pc bits 10 to 0
// - call fills pc bits 12 and 11 from upper latch bits 4 and 3
// - call takes two cycles and leaves the flags alone
// - invert complements the file register and updates zero
// - destination bit zero goes to accumulator, one back to the file
// - file clear writes zero to the file register and sets zero
// - file down subtracts one modulo 256 and updates zero
// - accumulator clear zeroes the accumulator and sets zero
// - down with skip decrements and leaves every flag unchanged
// - down with skip on zero result discards the next instruction
// - a skipped slot runs as a nop, so taken skips take two cycles
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`default_nettype none

module ccd_core_exec (
	input  wire logic                  clk,
	input  wire logic                  rst,
	// ahb-lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// fetched instructions
	input  wire logic                  instr_valid,
	input  wire logic [13:0]           instr_word,
	output logic                       instr_ready,
	// watchdog and power events
	input  wire logic                  dog_expired_evt,
	input  wire logic                  sleep_evt,
	output logic                       dog_timer_clear,
	output logic                       dog_prescale_clear,
	output logic [ccd_pkg::PC_W-1:0]   pc_out,
	output logic [ccd_pkg::PC_W-1:0]   stack_top
);
	import ccd_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_FLUSH = 2'b01
	} ccd_state_type;

	// ***********************************************************
	// declarations
	// ***********************************************************
	ccd_state_type   state_ff;
	ccd_state_type   nxt_state;
	ccd_bus_req_type bus_req_ff;
	ccd_dec_type     dec;
	logic [7:0]      file_mem [2**FILE_AW];
	logic [7:0]      accum_ff;
	logic            zero_ff;
	logic            dog_expired_flag_n_ff;
	logic            sleep_entered_flag_n_ff;
	logic [PC_W-1:0] pc_ff;
	logic [PC_W-1:0] pc_next_seq;
	logic [7:0]      pc_upper_latch_ff;
	logic [FILE_AW-1:0] file_ptr_ff;
	logic            dog_timer_clear_ff;
	logic            dog_prescale_clear_ff;
	logic            rd_done_ff;
	logic [31:0]     hrdata_ff;
	logic [31:0]     rd_mux;
	logic            bus_wr;
	logic            rd_wait;
	logic            take;
	logic            exec;
	logic [7:0]      file_operand;
	logic [7:0]      alu_result;
	logic            alu_zero;
	logic            push;
	logic            file_wr_exec;
	logic [7:0]      status_view;

	// ***********************************************************
	// instruction intake
	// ***********************************************************
	// a bus write owns the shared state for its data-phase cycle
	assign dec         = ccd_decode(instr_word);
	assign instr_ready = !bus_wr;
	assign take        = instr_valid && instr_ready;
	assign exec        = take && (state_ff == ST_RUN);
	assign push        = exec && (dec.op == OP_CALL);
	assign pc_next_seq = PC_W'(pc_ff + 1'b1);
	assign file_operand = file_mem[dec.faddr];
	assign file_wr_exec = exec && ((dec.op == OP_CLEAR_F) ||
		(dec.to_file && (dec.op == OP_INVERT || dec.op == OP_DOWN ||
		dec.op == OP_DOWN_SKIP)));

	ccd_file_alu u_alu (
		.op      (dec.op),
		.operand (file_operand),
		.result  (alu_result),
		.is_zero (alu_zero)
	);

	ccd_ret_stack #(
		.DEPTH (STACK_DEPTH),
		.WIDTH (PC_W)
	) u_stack (
		.clk       (clk),
		.rst       (rst),
		.push      (push),
		.push_data (pc_next_seq),
		.top       (stack_top)
	);

	// ***********************************************************
	// sequencing
	// ***********************************************************
	// second cycle of call or of a taken skip eats one fetched word
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_RUN: begin
				if (exec && dec.op == OP_CALL)
					nxt_state = ST_FLUSH;
				else if (exec && dec.op == OP_DOWN_SKIP && alu_zero)
					nxt_state = ST_FLUSH;
			end
			ST_FLUSH: begin
				if (take)
					nxt_state = ST_RUN;
			end
			default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state_ff <= ST_RUN;
		else
			state_ff <= nxt_state;
	end

	// program counter; a discarded word still advances past its slot
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_ff <= PC_RST;
		end else if (bus_wr && bus_req_ff.addr == REG_PC) begin
			pc_ff <= hwdata[PC_W-1:0];
		end else if (push) begin
			pc_ff <= {pc_upper_latch_ff[LATCH_UP_HI:LATCH_UP_LO],
				dec.target};
		end else if (take) begin
			pc_ff <= pc_next_seq;
		end
	end

	// upper latch is software state only
	always_ff @(posedge clk) begin
		if (rst)
			pc_upper_latch_ff <= LATCH_RST;
		else if (bus_wr && bus_req_ff.addr == REG_PC_LATCH)
			pc_upper_latch_ff <= hwdata[7:0];
	end

	// ***********************************************************
	// data path
	// ***********************************************************
	// file memory has no reset; software must initialise it
	always_ff @(posedge clk) begin
		if (bus_wr && bus_req_ff.addr == REG_FILE_DATA)
			file_mem[file_ptr_ff] <= hwdata[7:0];
		else if (file_wr_exec)
			file_mem[dec.faddr] <= (dec.op == OP_CLEAR_F) ?
				8'h00 : alu_result;
	end

	// accumulator
	always_ff @(posedge clk) begin
		if (rst) begin
			accum_ff <= ACCUM_RST;
		end else if (bus_wr && bus_req_ff.addr == REG_ACCUM) begin
			accum_ff <= hwdata[7:0];
		end else if (exec && dec.op == OP_CLEAR_W) begin
			accum_ff <= 8'h00;
		end else if (exec && !dec.to_file && (dec.op == OP_INVERT ||
			dec.op == OP_DOWN || dec.op == OP_DOWN_SKIP)) begin
			accum_ff <= alu_result;
		end
	end

	// zero flag; skip variant and call leave it alone
	always_ff @(posedge clk) begin
		if (rst) begin
			zero_ff <= 1'b0;
		end else if (bus_wr && bus_req_ff.addr == REG_STATUS) begin
			zero_ff <= hwdata[STAT_ZERO_BIT];
		end else if (exec && (dec.op == OP_INVERT ||
			dec.op == OP_DOWN)) begin
			zero_ff <= alu_zero;
		end else if (exec && (dec.op == OP_CLEAR_F ||
			dec.op == OP_CLEAR_W)) begin
			zero_ff <= 1'b1;
		end
	end

	// active-low flags; a watchdog or sleep event beats a kick
	always_ff @(posedge clk) begin
		if (rst) begin
			dog_expired_flag_n_ff   <= 1'b1;
			sleep_entered_flag_n_ff <= 1'b1;
		end else begin
			if (dog_expired_evt)
				dog_expired_flag_n_ff <= 1'b0;
			else if (exec && dec.op == OP_DOG_KICK)
				dog_expired_flag_n_ff <= 1'b1;
			if (sleep_evt)
				sleep_entered_flag_n_ff <= 1'b0;
			else if (exec && dec.op == OP_DOG_KICK)
				sleep_entered_flag_n_ff <= 1'b1;
		end
	end

	// one-cycle clears to the watchdog counter and its prescaler
	always_ff @(posedge clk) begin
		if (rst) begin
			dog_timer_clear_ff    <= 1'b0;
			dog_prescale_clear_ff <= 1'b0;
		end else begin
			dog_timer_clear_ff    <= exec && dec.op == OP_DOG_KICK;
			dog_prescale_clear_ff <= exec && dec.op == OP_DOG_KICK;
		end
	end

	assign dog_timer_clear    = dog_timer_clear_ff;
	assign dog_prescale_clear = dog_prescale_clear_ff;
	assign pc_out             = pc_ff;

	// ***********************************************************
	// ahb-lite slave
	// ***********************************************************
	// only the low 12 address bits decode; hsize is not checked
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_req_ff <= '0;
		end else if (hready) begin
			bus_req_ff.valid <= hsel && (htrans == HTRANS_NONSEQ ||
				htrans == 2'h3);
			bus_req_ff.write <= hwrite;
			bus_req_ff.addr  <= haddr[11:0];
		end
	end

	assign bus_wr  = bus_req_ff.valid && bus_req_ff.write;
	// reads take one wait state so that a write just before is seen
	assign rd_wait = bus_req_ff.valid && !bus_req_ff.write && !rd_done_ff;
	assign hreadyout = !rd_wait;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	// file pointer used by the data window
	always_ff @(posedge clk) begin
		if (rst)
			file_ptr_ff <= '0;
		else if (bus_wr && bus_req_ff.addr == REG_FILE_ADDR)
			file_ptr_ff <= hwdata[FILE_AW-1:0];
	end

	assign status_view = {3'b000, dog_expired_flag_n_ff,
		sleep_entered_flag_n_ff, zero_ff, 2'b00};

	// read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (bus_req_ff.addr)
			REG_ACCUM:     rd_mux = {24'h00_0000, accum_ff};
			REG_STATUS:    rd_mux = {24'h00_0000, status_view};
			REG_PC:        rd_mux = {19'h0_0000, pc_ff};
			REG_PC_LATCH:  rd_mux = {24'h00_0000, pc_upper_latch_ff};
			REG_STACK_TOP: rd_mux = {19'h0_0000, stack_top};
			REG_FILE_ADDR: rd_mux = {25'h000_0000, file_ptr_ff};
			REG_FILE_DATA: rd_mux = {24'h00_0000, file_mem[file_ptr_ff]};
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// read data captured at the end of the wait state
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata_ff  <= 32'h0000_0000;
			rd_done_ff <= 1'b0;
		end else begin
			rd_done_ff <= rd_wait;
			if (rd_wait)
				hrdata_ff <= rd_mux;
		end
	end

	// ***********************************************************
	// checks
	// ***********************************************************
	a_kick_timer_clear: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_DOG_KICK) |=> dog_timer_clear ##1
		!dog_timer_clear || $past(exec))
		else $error("kick did not clear watchdog count");

	a_kick_prescale: assert property (
		@(posedge clk) disable iff (rst)
		dog_prescale_clear |-> $past(exec) && dog_timer_clear)
		else $error("prescaler clear without kick");

	a_kick_flags_set: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_DOG_KICK && !dog_expired_evt &&
		!sleep_evt) |=> dog_expired_flag_n_ff &&
		sleep_entered_flag_n_ff && $stable(zero_ff))
		else $error("kick flags wrong");

	a_call_push_ret: assert property (
		@(posedge clk) disable iff (rst)
		push |=> stack_top == $past(pc_ff) + 13'h0001)
		else $error("call pushed wrong return address");

	a_call_target_pc: assert property (
		@(posedge clk) disable iff (rst)
		push |=> pc_ff[10:0] == $past(instr_word[10:0]))
		else $error("call target not loaded");

	a_call_upper_pc: assert property (
		@(posedge clk) disable iff (rst)
		push |=> pc_ff[12:11] == $past(pc_upper_latch_ff[4:3]))
		else $error("call upper pc bits wrong");

	a_call_two_cyc: assert property (
		@(posedge clk) disable iff (rst)
		push |=> state_ff == ST_FLUSH && $stable(zero_ff) &&
		$stable(dog_expired_flag_n_ff))
		else $error("call not two cycles or flags moved");

	a_invert_to_acc: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_INVERT && !dec.to_file) |=>
		accum_ff == ~$past(file_operand) &&
		zero_ff == ($past(file_operand) == 8'hff))
		else $error("invert result or zero wrong");

	a_down_zero_flag: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_DOWN && !dec.to_file) |=>
		accum_ff == $past(file_operand) - 8'h01 &&
		zero_ff == ($past(file_operand) == 8'h01))
		else $error("decrement result or zero wrong");

	a_clear_sets_zero: assert property (
		@(posedge clk) disable iff (rst)
		(exec && (dec.op == OP_CLEAR_W || dec.op == OP_CLEAR_F)) |=>
		zero_ff && (accum_ff == 8'h00 || $past(dec.op == OP_CLEAR_F)))
		else $error("clear did not set zero");

	a_skip_keep_flags: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_DOWN_SKIP) |=> $stable(zero_ff))
		else $error("skip decrement changed zero flag");

	a_skip_discard: assert property (
		@(posedge clk) disable iff (rst)
		(state_ff == ST_FLUSH && take) |=> state_ff == ST_RUN &&
		$stable(accum_ff) && $stable(zero_ff) && !dog_timer_clear)
		else $error("discarded slot had an effect");

	a_skip_two_cyc: assert property (
		@(posedge clk) disable iff (rst)
		(exec && dec.op == OP_DOWN_SKIP) |=>
		(state_ff == ST_FLUSH) == ($past(file_operand) == 8'h01))
		else $error("skip decision wrong");

endmodule : ccd_core_exec

`default_nettype wire

// ===== ccd_core_exec_tb_top.sv
// self-checking bench for the clear/decrement/call execute stage
// assumes ccd_pkg and ccd_core_exec compiled first; bench drives all ports
`default_nettype none

module ccd_core_exec_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ccd_pkg::*;

	// ***********************************************************
	// signals and device under test
	// ***********************************************************
	logic               clk;
	logic               rst;
	logic               hsel;
	logic [31:0]        haddr;
	logic [1:0]         htrans;
	logic               hwrite;
	logic [2:0]         hsize;
	logic [31:0]        hwdata;
	logic               hready;
	logic               hreadyout;
	logic               hresp;
	logic [31:0]        hrdata;
	logic               instr_valid;
	logic [13:0]        instr_word;
	logic               instr_ready;
	logic               dog_expired_evt;
	logic               sleep_evt;
	logic               dog_timer_clear;
	logic               dog_prescale_clear;
	logic [PC_W-1:0]    pc_out;
	logic [PC_W-1:0]    stack_top;
	logic [31:0]        rd;
	int                 mismatches;
	int                 tests_run;
	int                 cycles;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	ccd_core_exec u_dut (
		.clk                (clk),
		.rst                (rst),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hready),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.hrdata             (hrdata),
		.instr_valid        (instr_valid),
		.instr_word         (instr_word),
		.instr_ready        (instr_ready),
		.dog_expired_evt    (dog_expired_evt),
		.sleep_evt          (sleep_evt),
		.dog_timer_clear    (dog_timer_clear),
		.dog_prescale_clear (dog_prescale_clear),
		.pc_out             (pc_out),
		.stack_top          (stack_top)
	);

	// operand table: opcode, destination, input, result, zero
	logic [5:0] t_op [6] = '{OPC_DOWN_HI, OPC_DOWN_HI, OPC_INVERT_HI,
		OPC_INVERT_HI, OPC_CLEAR_HI, OPC_CLEAR_HI};
	logic       t_d [6]   = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [7:0] t_in [6]  = '{8'h01, 8'h00, 8'hff, 8'h5a, 8'h77, 8'h77};
	logic [7:0] t_res [6] = '{8'h00, 8'hff, 8'h00, 8'ha5, 8'h00, 8'h00};
	logic       t_z [6]   = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	// ***********************************************************
	// clock, timeout and helpers
	// ***********************************************************
	always #20 clk = ~clk;

	// a hung handshake ends here instead of running forever
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ready sampled just before the edge, so no race with its update
	task automatic wait_rdy();
		do begin
			@(negedge clk);
			rd = hrdata;
		end while (hreadyout !== 1'b1);
		@(posedge clk);
	endtask : wait_rdy

	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {20'h0_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask : rd_chk

	// valid stays up so that words can follow back to back
	task automatic exec(input logic [13:0] w);
		instr_valid <= 1'b1;
		instr_word  <= w;
		do begin
			@(negedge clk);
		end while (instr_ready !== 1'b1);
		@(posedge clk);
	endtask : exec

	task automatic idle();
		instr_valid <= 1'b0;
		@(posedge clk);
	endtask : idle

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		dog_expired_evt = 1'b0;
		sleep_evt = 1'b0;
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);

		// reset state, an unmapped offset reads zero
		chk({19'h0_0000, pc_out}, 32'h0000_0000);
		chk({19'h0_0000, stack_top}, 32'h0000_0000);
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
		rd_chk(REG_ACCUM, 32'h0000_0000);
		rd_chk(REG_STATUS, 32'h0000_0018);
		rd_chk(REG_PC_LATCH, 32'h0000_0000);
		rd_chk(12'h020, 32'h0000_0000);

		// file ops at the top file address, both destinations
		for (int i = 0; i < 6; i++) begin
			wr(REG_FILE_ADDR, 32'h0000_007f);
			wr(REG_FILE_DATA, {24'h00_0000, t_in[i]});
			wr(REG_ACCUM, 32'h0000_0033);
			wr(REG_STATUS, t_z[i] ? 32'h0000_0018 : 32'h0000_001c);
			exec({t_op[i], t_d[i], 7'h7f});
			idle();
			rd_chk(REG_ACCUM, {24'h00_0000, t_d[i] ? 8'h33 : t_res[i]});
			rd_chk(REG_FILE_DATA, {24'h00_0000, t_d[i] ? t_res[i] : t_in[i]});
			rd_chk(REG_STATUS, t_z[i] ? 32'h0000_001c : 32'h0000_0018);
		end

		// skip on zero: the following clear must be dropped
		wr(REG_FILE_ADDR, 32'h0000_0005);
		wr(REG_FILE_DATA, 32'h0000_0001);
		wr(REG_ACCUM, 32'h0000_005a);
		wr(REG_STATUS, 32'h0000_0018);
		wr(REG_PC, 32'h0000_0010);
		exec({OPC_SKIP_HI, 1'b1, 7'h05});
		exec({OPC_CLEAR_HI, 1'b0, 7'h00});
		idle();
		rd_chk(REG_FILE_DATA, 32'h0000_0000);
		rd_chk(REG_ACCUM, 32'h0000_005a);
		rd_chk(REG_STATUS, 32'h0000_0018);
		chk({19'h0_0000, pc_out}, 32'h0000_0012);

		// nonzero skip result: next word runs
		wr(REG_FILE_DATA, 32'h0000_0003);
		wr(REG_STATUS, 32'h0000_001c);
		exec({OPC_SKIP_HI, 1'b0, 7'h05});
		exec({OPC_DOWN_HI, 1'b1, 7'h05});
		idle();
		rd_chk(REG_ACCUM, 32'h0000_0002);
		rd_chk(REG_FILE_DATA, 32'h0000_0002);
		rd_chk(REG_STATUS, 32'h0000_0018);
		chk({19'h0_0000, pc_out}, 32'h0000_0014);

		// call with latch bits 4:3 = 2'b10, word after it dropped
		wr(REG_PC_LATCH, 32'h0000_0017);
		wr(REG_PC, 32'h0000_0123);
		wr(REG_STATUS, 32'h0000_001c);
		exec({OPC_CALL_HI, 11'h400});
		exec({OPC_CLEAR_HI, 1'b0, 7'h00});
		idle();
		chk({19'h0_0000, pc_out}, 32'h0000_1401);
		chk({19'h0_0000, stack_top}, 32'h0000_0124);
		rd_chk(REG_STACK_TOP, 32'h0000_0124);
		rd_chk(REG_ACCUM, 32'h0000_0002);
		rd_chk(REG_STATUS, 32'h0000_001c);

		// events clear both flags, the kick sets them again
		dog_expired_evt <= 1'b1;
		sleep_evt <= 1'b1;
		@(posedge clk);
		dog_expired_evt <= 1'b0;
		sleep_evt <= 1'b0;
		@(posedge clk);
		rd_chk(REG_STATUS, 32'h0000_0004);
		exec(OPC_DOG_KICK);
		instr_valid <= 1'b0;
		@(negedge clk);
		chk({30'h0000_0000, dog_timer_clear, dog_prescale_clear}, 32'h0000_0003);
		@(negedge clk);
		chk({30'h0000_0000, dog_timer_clear, dog_prescale_clear}, 32'h0000_0000);
		@(posedge clk);
		rd_chk(REG_STATUS, 32'h0000_001c);

		report_and_stop();
	end

endmodule : ccd_core_exec_tb_top

`default_nettype wire
